// [verification/ctx_exec_tb.sv]
// self-checking bench for the transfer and test execution block
`timescale 1ns/1ps
module ctx_exec_tb;
  typedef struct packed {
    logic [23:0] code;
    logic [7:0] a;
    logic [15:0] hx;
    logic [15:0] sp;
    logic [15:0] ea;
    logic [7:0] m;
    logic [3:0] len;
    logic [3:0] nrd;
    logic [7:0] xa;
    logic [15:0] xhx;
    logic [15:0] xsp;
    logic [7:0] xf;
  } ctx_row_type;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [15:0] mem_addr_o;
  logic mem_rd_o;
  logic [7:0] mem_data_i;
  logic [7:0] mem [0:65535];
  logic [15:0] last_ra;
  logic [31:0] q;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  int nrd_cnt = 0;
  ctx_row_type rows [10];

  ctx_exec dut_u (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .mem_addr_o(mem_addr_o),
    .mem_rd_o(mem_rd_o),
    .mem_data_i(mem_data_i)
  );

  always #12.5 clk_i = ~clk_i;

  // byte at the strobed address stands in the strobe cycle
  assign mem_data_i = mem[mem_addr_o];

  // read tally and hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (mem_rd_o === 1'b1) begin
      nrd_cnt++;
      last_ra = mem_addr_o;
    end
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] e,
      input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask

  // one classic cycle, entered just after a rising edge
  task automatic wb(input logic we, input logic [7:0] adr,
      input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hF;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 50) mismatches++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] adr,
      input logic [31:0] e);
    wb(1'b0, adr, 32'h0000_0000);
    chk(name, e, q);
  endtask

  // start at 0x0010 and poll busy
  task automatic start();
    wb(1'b1, ctx_pkg::OFS_PC, 32'h0000_0010);
    nrd_cnt = 0;
    wb(1'b1, ctx_pkg::OFS_CTRL, 32'h0000_0001);
    q = 32'h0000_0001;
    for (int i = 0; i < 20 && q[0] !== 1'b0; i++)
      wb(1'b0, ctx_pkg::OFS_STATUS, 32'h0000_0000);
  endtask

  task automatic run(input ctx_row_type r);
    mem[16'h0010] = r.code[23:16];
    mem[16'h0011] = r.code[15:8];
    mem[16'h0012] = r.code[7:0];
    mem[r.ea] = r.m;
    wb(1'b1, ctx_pkg::OFS_ACC, 32'(r.a));
    wb(1'b1, ctx_pkg::OFS_INDEX_LOW, 32'(r.hx[7:0]));
    wb(1'b1, ctx_pkg::OFS_INDEX_HIGH, 32'(r.hx[15:8]));
    wb(1'b1, ctx_pkg::OFS_STACK, 32'(r.sp));
    wb(1'b1, ctx_pkg::OFS_FLAGS, 32'h0000_00E9);
    start();
    chk("reads", 32'(r.nrd), 32'(nrd_cnt));
    chk("last addr", 32'(r.nrd > r.len ? r.ea :
        16'(16'h0010 + r.len - 1)), 32'(last_ra));
    rd_chk("acc", ctx_pkg::OFS_ACC, 32'(r.xa));
    rd_chk("x low", ctx_pkg::OFS_INDEX_LOW, 32'(r.xhx[7:0]));
    rd_chk("x high", ctx_pkg::OFS_INDEX_HIGH, 32'(r.xhx[15:8]));
    rd_chk("stack", ctx_pkg::OFS_STACK, 32'(r.xsp));
    rd_chk("flags", ctx_pkg::OFS_FLAGS, 32'(r.xf));
    rd_chk("pc", ctx_pkg::OFS_PC, 32'(16'h0010 + r.len));
  endtask

  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    rows[0] = '{24'h85_0000, 8'h00, 16'h0000, 16'h00FF, 16'h0000, 8'h00,
      4'h1, 4'h1, 8'hE9, 16'h0000, 16'h00FF, 8'hE9};
    rows[1] = '{24'h4D_0000, 8'h80, 16'h0000, 16'h00FF, 16'h0000, 8'h00,
      4'h1, 4'h1, 8'h80, 16'h0000, 16'h00FF, 8'h6D};
    rows[2] = '{24'h5D_0000, 8'h55, 16'h1200, 16'h00FF, 16'h0000, 8'h00,
      4'h1, 4'h1, 8'h55, 16'h1200, 16'h00FF, 8'h6B};
    rows[3] = '{24'h3D_4000, 8'h00, 16'h0000, 16'h00FF, 16'h0040, 8'h7F,
      4'h2, 4'h3, 8'h00, 16'h0000, 16'h00FF, 8'h69};
    rows[4] = '{24'h6D_0500, 8'h00, 16'h0200, 16'h00FF, 16'h0205, 8'h00,
      4'h2, 4'h3, 8'h00, 16'h0200, 16'h00FF, 8'h6B};
    rows[5] = '{24'h7D_0000, 8'h00, 16'h0300, 16'h00FF, 16'h0300, 8'h90,
      4'h1, 4'h2, 8'h00, 16'h0300, 16'h00FF, 8'h6D};
    rows[6] = '{24'h9E_6D03, 8'h00, 16'h0000, 16'h00F0, 16'h00F3, 8'h01,
      4'h3, 4'h4, 8'h00, 16'h0000, 16'h00F0, 8'h69};
    rows[7] = '{24'h95_0000, 8'h00, 16'h0000, 16'h12FF, 16'h0000, 8'h00,
      4'h1, 4'h1, 8'h00, 16'h1300, 16'h12FF, 8'hE9};
    rows[8] = '{24'h9F_0000, 8'h00, 16'h34A5, 16'h00FF, 16'h0000, 8'h00,
      4'h1, 4'h1, 8'hA5, 16'h34A5, 16'h00FF, 8'hE9};
    rows[9] = '{24'h94_0000, 8'h00, 16'h1300, 16'h00FF, 16'h0000, 8'h00,
      4'h1, 4'h1, 8'h00, 16'h1300, 16'h12FF, 8'hE9};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (rows[i]) run(rows[i]);
    // prefix followed by a foreign opcode is refused
    mem[16'h0010] = 8'h9E;
    mem[16'h0011] = 8'h00;
    start();
    chk("illegal", 32'h0000_0002, q & 32'h0000_0002);
    // opcode outside the group is refused
    mem[16'h0010] = 8'h00;
    start();
    chk("unknown op", 32'h0000_0002, q & 32'h0000_0002);
    run(rows[0]);
    rd_chk("status", ctx_pkg::OFS_STATUS, 32'h0000_8500);
    rd_chk("unmapped", 8'h40, 32'h0000_0000);
    // second reset after the last run restores the core
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk("rst flags", ctx_pkg::OFS_FLAGS, 32'h0000_0068);
    rd_chk("rst stack", ctx_pkg::OFS_STACK, 32'h0000_00FF);
    rd_chk("rst acc", ctx_pkg::OFS_ACC, 32'h0000_0000);
    rd_chk("rst pc", ctx_pkg::OFS_PC, 32'h0000_0000);
    end_sim();
  end
endmodule

// [verilog/ctx_exec.sv]
// execution block for flag, index, stack transfers and operand tests
`timescale 1ns/1ps
module ctx_exec #(
  parameter int WB_ADR_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [15:0] mem_addr_o,
  output logic mem_rd_o,
  input wire logic [7:0] mem_data_i
);
  if (WB_ADR_W < 5 || WB_ADR_W > 8) begin : g_bad_width
    $error("WB_ADR_W must lie between 5 and 8");
  end

  ctx_pkg::ctx_core_type core_ff, nxt_core;
  ctx_pkg::ctx_state_type state_ff, nxt_state;
  logic [7:0] op_ff, nxt_op;
  logic [2:0] cnt_ff, nxt_cnt;
  logic [2:0] total_ff, nxt_total;
  logic illegal_ff, nxt_illegal;
  logic ack_ff, nxt_ack;
  logic [31:0] dat_ff, nxt_dat;
  logic [15:0] addr_ff, nxt_addr;
  logic rd_ff, nxt_rd;
  logic [7:0] adr8;
  logic req;
  logic [15:0] pair;
  logic [7:0] tst_val;
  logic commit;

  assign adr8 = 8'(wb_adr_i);
  assign req = wb_cyc_i & wb_stb_i;
  assign pair = {core_ff.x_high, core_ff.x_low};

  always_comb begin
    nxt_core = core_ff;
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_cnt = cnt_ff;
    nxt_total = total_ff;
    nxt_illegal = illegal_ff;
    nxt_addr = addr_ff;
    nxt_rd = 1'b0;
    nxt_ack = req & ~ack_ff;
    nxt_dat = 32'h0000_0000;
    tst_val = mem_data_i;
    commit = 1'b0;
    if (state_ff != ctx_pkg::ST_IDLE) begin
      nxt_cnt = cnt_ff + 3'h1;
    end
    unique case (state_ff)
      ctx_pkg::ST_IDLE: begin
        if (req & ack_ff & wb_we_i & wb_sel_i[0] &
            (adr8 == ctx_pkg::OFS_CTRL) & wb_dat_i[0]) begin
          nxt_state = ctx_pkg::ST_OPC;
          nxt_addr = core_ff.pc;
          nxt_rd = 1'b1;
          nxt_core.pc = core_ff.pc + 16'h0001;
          nxt_cnt = 3'h1;
          nxt_illegal = 1'b0;
        end
      end
      ctx_pkg::ST_OPC: begin
        nxt_op = mem_data_i;
        nxt_state = ctx_pkg::ST_IDLE;
        unique case (mem_data_i)
          ctx_pkg::OP_PREFIX: begin
            nxt_state = ctx_pkg::ST_PRE;
            nxt_addr = core_ff.pc;
            nxt_rd = 1'b1;
            nxt_core.pc = core_ff.pc + 16'h0001;
          end
          ctx_pkg::OP_TEST_DIR, ctx_pkg::OP_TEST_OFS8: begin
            nxt_total = (mem_data_i == ctx_pkg::OP_TEST_DIR) ?
              ctx_pkg::CYC_TEST_DIR : ctx_pkg::CYC_TEST_OFS8;
            nxt_state = ctx_pkg::ST_OPR;
            nxt_addr = core_ff.pc;
            nxt_rd = 1'b1;
            nxt_core.pc = core_ff.pc + 16'h0001;
          end
          ctx_pkg::OP_TEST_NO_OFS: begin
            nxt_total = ctx_pkg::CYC_TEST_NO_OFS;
            nxt_state = ctx_pkg::ST_MEM;
            nxt_addr = pair;
            nxt_rd = 1'b1;
          end
          ctx_pkg::OP_STACK_TO_INDEX_PAIR,
          ctx_pkg::OP_INDEX_PAIR_TO_STACK: begin
            nxt_total = ctx_pkg::CYC_PAIR_XFER;
            nxt_state = ctx_pkg::ST_WAIT;
          end
          ctx_pkg::OP_FLAGS_TO_ACC: begin
            nxt_total = ctx_pkg::CYC_ONE;
            nxt_core.acc = core_ff.flags;
            commit = 1'b1;
          end
          ctx_pkg::OP_INDEX_LOW_TO_ACC: begin
            nxt_total = ctx_pkg::CYC_ONE;
            nxt_core.acc = core_ff.x_low;
            commit = 1'b1;
          end
          ctx_pkg::OP_TEST_ACC, ctx_pkg::OP_TEST_INDEX_LOW: begin
            nxt_total = ctx_pkg::CYC_ONE;
            tst_val = (mem_data_i == ctx_pkg::OP_TEST_ACC) ?
              core_ff.acc : core_ff.x_low;
            nxt_core.flags[ctx_pkg::FLAG_V] = 1'b0;
            nxt_core.flags[ctx_pkg::FLAG_N] = tst_val[7];
            nxt_core.flags[ctx_pkg::FLAG_Z] = (tst_val == 8'h00);
            commit = 1'b1;
          end
          default: nxt_illegal = 1'b1;
        endcase
      end
      ctx_pkg::ST_PRE: begin
        nxt_op = mem_data_i;
        nxt_state = ctx_pkg::ST_IDLE;
        if (mem_data_i == ctx_pkg::OP_TEST_OFS8) begin
          nxt_total = ctx_pkg::CYC_TEST_STACK;
          nxt_state = ctx_pkg::ST_OPR;
          nxt_addr = core_ff.pc;
          nxt_rd = 1'b1;
          nxt_core.pc = core_ff.pc + 16'h0001;
        end else begin
          nxt_illegal = 1'b1;
        end
      end
      ctx_pkg::ST_OPR: begin
        nxt_state = ctx_pkg::ST_MEM;
        nxt_rd = 1'b1;
        if (op_ff == ctx_pkg::OP_TEST_DIR) begin
          nxt_addr = {8'h00, mem_data_i};
        end else if (cnt_ff == 3'h3) begin
          nxt_addr = core_ff.sp + {8'h00, mem_data_i};
        end else begin
          nxt_addr = pair + {8'h00, mem_data_i};
        end
      end
      ctx_pkg::ST_MEM: begin
        nxt_state = ctx_pkg::ST_IDLE;
        nxt_core.flags[ctx_pkg::FLAG_V] = 1'b0;
        nxt_core.flags[ctx_pkg::FLAG_N] = mem_data_i[7];
        nxt_core.flags[ctx_pkg::FLAG_Z] = (mem_data_i == 8'h00);
        commit = 1'b1;
      end
      ctx_pkg::ST_WAIT: begin
        nxt_state = ctx_pkg::ST_IDLE;
        commit = 1'b1;
        if (op_ff == ctx_pkg::OP_STACK_TO_INDEX_PAIR) begin
          {nxt_core.x_high, nxt_core.x_low} =
            core_ff.sp + 16'h0001;
        end else begin
          nxt_core.sp = pair - 16'h0001;
        end
      end
    endcase
    // register bus: write at the acknowledging edge
    if (req & ack_ff & wb_we_i & (state_ff == ctx_pkg::ST_IDLE)) begin
      unique case (adr8)
        ctx_pkg::OFS_ACC:
          if (wb_sel_i[0]) nxt_core.acc = wb_dat_i[7:0];
        ctx_pkg::OFS_INDEX_LOW:
          if (wb_sel_i[0]) nxt_core.x_low = wb_dat_i[7:0];
        ctx_pkg::OFS_INDEX_HIGH:
          if (wb_sel_i[0]) nxt_core.x_high = wb_dat_i[7:0];
        ctx_pkg::OFS_FLAGS:
          if (wb_sel_i[0]) nxt_core.flags = wb_dat_i[7:0];
        ctx_pkg::OFS_STACK: begin
          if (wb_sel_i[0]) nxt_core.sp[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1]) nxt_core.sp[15:8] = wb_dat_i[15:8];
        end
        ctx_pkg::OFS_PC: begin
          if (wb_sel_i[0]) nxt_core.pc[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1]) nxt_core.pc[15:8] = wb_dat_i[15:8];
        end
        default: ;
      endcase
    end
    if (req & ~ack_ff & ~wb_we_i) begin
      unique case (adr8)
        ctx_pkg::OFS_STATUS:
          nxt_dat = {16'h0000, op_ff, 6'h00, illegal_ff,
                     state_ff != ctx_pkg::ST_IDLE};
        ctx_pkg::OFS_ACC: nxt_dat = {24'h00_0000, core_ff.acc};
        ctx_pkg::OFS_INDEX_LOW: nxt_dat = {24'h00_0000, core_ff.x_low};
        ctx_pkg::OFS_INDEX_HIGH: nxt_dat = {24'h00_0000, core_ff.x_high};
        ctx_pkg::OFS_FLAGS: nxt_dat = {24'h00_0000, core_ff.flags};
        ctx_pkg::OFS_STACK: nxt_dat = {16'h0000, core_ff.sp};
        ctx_pkg::OFS_PC: nxt_dat = {16'h0000, core_ff.pc};
        default: nxt_dat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_ff <= '{acc: 8'h00, x_low: 8'h00, x_high: 8'h00,
                   sp: ctx_pkg::RST_STACK, flags: ctx_pkg::RST_FLAGS,
                   pc: ctx_pkg::RST_PC};
      state_ff <= ctx_pkg::ST_IDLE;
      op_ff <= 8'h00;
      cnt_ff <= 3'h0;
      total_ff <= 3'h0;
      illegal_ff <= 1'b0;
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
      addr_ff <= 16'h0000;
      rd_ff <= 1'b0;
    end else begin
      core_ff <= nxt_core;
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      cnt_ff <= nxt_cnt;
      total_ff <= nxt_total;
      illegal_ff <= nxt_illegal;
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
      addr_ff <= nxt_addr;
      rd_ff <= nxt_rd;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign mem_addr_o = addr_ff;
  assign mem_rd_o = rd_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_flags_copy: assert property (
    state_ff == ctx_pkg::ST_OPC && mem_data_i == ctx_pkg::OP_FLAGS_TO_ACC
    |=> core_ff.acc == $past(core_ff.flags) && $stable(core_ff.flags))
    else $error("flags copy wrong");
  chk_test_flags: assert property (
    state_ff == ctx_pkg::ST_MEM |=> !core_ff.flags[ctx_pkg::FLAG_V] &&
    core_ff.flags[ctx_pkg::FLAG_Z] == ($past(mem_data_i) == 8'h00) &&
    core_ff.flags[ctx_pkg::FLAG_N] == $past(mem_data_i[7]) &&
    core_ff.flags[6:3] == $past(core_ff.flags[6:3]) &&
    core_ff.flags[0] == $past(core_ff.flags[0]))
    else $error("test flags wrong");
  chk_test_cycles: assert property (
    commit |-> cnt_ff == nxt_total)
    else $error("cycle total wrong");
  chk_stack_to_pair: assert property (
    state_ff == ctx_pkg::ST_WAIT && op_ff == ctx_pkg::OP_STACK_TO_INDEX_PAIR
    |=> {core_ff.x_high, core_ff.x_low} == $past(core_ff.sp) + 16'h0001
    && $stable(core_ff.flags))
    else $error("stack to pair wrong");
  chk_low_to_acc: assert property (
    state_ff == ctx_pkg::ST_OPC && mem_data_i == ctx_pkg::OP_INDEX_LOW_TO_ACC
    |=> core_ff.acc == $past(core_ff.x_low) && state_ff == ctx_pkg::ST_IDLE)
    else $error("index low copy wrong");
  chk_pair_to_stack: assert property (
    state_ff == ctx_pkg::ST_OPC && mem_data_i == ctx_pkg::OP_INDEX_PAIR_TO_STACK
    ##1 state_ff == ctx_pkg::ST_WAIT |=> core_ff.sp ==
    {$past(core_ff.x_high, 2), $past(core_ff.x_low, 2)} - 16'h0001)
    else $error("pair to stack wrong");
  chk_operand_fetch: assert property (
    state_ff == ctx_pkg::ST_OPR |-> mem_addr_o == core_ff.pc - 16'h0001
    && (op_ff == ctx_pkg::OP_TEST_DIR || op_ff == ctx_pkg::OP_TEST_OFS8))
    else $error("operand fetch wrong");
  chk_pair_address: assert property (
    state_ff == ctx_pkg::ST_MEM && op_ff == ctx_pkg::OP_TEST_NO_OFS
    |-> mem_addr_o == {core_ff.x_high, core_ff.x_low})
    else $error("pair address wrong");
  chk_prefix_seq: assert property (
    state_ff == ctx_pkg::ST_PRE |-> $past(state_ff) == ctx_pkg::ST_OPC &&
    $past(mem_data_i) == ctx_pkg::OP_PREFIX && cnt_ff == 3'h2)
    else $error("prefix sequence wrong");
endmodule

// [verilog/ctx_pkg.sv]
// constants and types for the transfer and test execution block
package ctx_pkg;
  // opcodes
  localparam logic [7:0] OP_FLAGS_TO_ACC = 8'h85;
  localparam logic [7:0] OP_TEST_DIR = 8'h3D;
  localparam logic [7:0] OP_TEST_ACC = 8'h4D;
  localparam logic [7:0] OP_TEST_INDEX_LOW = 8'h5D;
  localparam logic [7:0] OP_TEST_OFS8 = 8'h6D;
  localparam logic [7:0] OP_TEST_NO_OFS = 8'h7D;
  localparam logic [7:0] OP_PREFIX = 8'h9E;
  localparam logic [7:0] OP_STACK_TO_INDEX_PAIR = 8'h95;
  localparam logic [7:0] OP_INDEX_LOW_TO_ACC = 8'h9F;
  localparam logic [7:0] OP_INDEX_PAIR_TO_STACK = 8'h94;
  // cycle totals
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TEST_DIR = 3'h3;
  localparam logic [2:0] CYC_TEST_OFS8 = 3'h3;
  localparam logic [2:0] CYC_TEST_NO_OFS = 3'h2;
  localparam logic [2:0] CYC_TEST_STACK = 3'h4;
  localparam logic [2:0] CYC_PAIR_XFER = 3'h2;
  // condition flag bit positions
  localparam int FLAG_V = 7;
  localparam int FLAG_N = 2;
  localparam int FLAG_Z = 1;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ACC = 8'h08;
  localparam logic [7:0] OFS_INDEX_LOW = 8'h0C;
  localparam logic [7:0] OFS_INDEX_HIGH = 8'h10;
  localparam logic [7:0] OFS_STACK = 8'h14;
  localparam logic [7:0] OFS_FLAGS = 8'h18;
  localparam logic [7:0] OFS_PC = 8'h1C;
  // reset values
  localparam logic [7:0] RST_FLAGS = 8'h68;
  localparam logic [15:0] RST_STACK = 16'h00FF;
  localparam logic [15:0] RST_PC = 16'h0000;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] x_low;
    logic [7:0] x_high;
    logic [15:0] sp;
    logic [7:0] flags;
    logic [15:0] pc;
  } ctx_core_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPC = 3'b001,
    ST_PRE = 3'b010,
    ST_OPR = 3'b011,
    ST_MEM = 3'b100,
    ST_WAIT = 3'b101
  } ctx_state_type;
endpackage
